/* File: design/sprc_core.sv */
// Purpose: auto precharge, burst terminate, auto and self refresh control
// Assumes: commands sampled on rising clk_in; controller keeps its timings
// Notes: emits refresh row strobes and per-bank open-row state
`timescale 1ns/10ps
`default_nettype none
module sprc_core #(
    parameter bit AUTOMOTIVE_GRADE = 1'b0,
    parameter int SELF_CYC = sprc_pkg::SELF_REF_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cke_in,
    input wire sprc_pkg::sprc_cmd_t cmd_in,
    input wire logic [8:0] burst_len_in,
    output logic [sprc_pkg::BANKS-1:0] bank_open_out,
    output logic burst_active_out,
    output logic self_refresh_out,
    output logic [sprc_pkg::ROW_W-1:0] refresh_row_out,
    output logic refresh_strobe_out
);
    sprc_pkg::sprc_state_t st_r, st_nxt;
    logic [sprc_pkg::BANKS-1:0] open_r, open_nxt;
    logic [8:0] left_r, left_nxt;
    logic [1:0] bbank_r, bbank_nxt;
    logic ap_r, ap_nxt;
    logic full_r, full_nxt;
    logic auto_step;
    logic in_self;

    // decode one command code
    function automatic logic is_cmd(input sprc_pkg::sprc_cmd_t c, input logic [3:0] code);
        return c.cmd == code;
    endfunction

    // ------------------------------------------------------------
    // command and burst control
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        open_nxt = open_r;
        left_nxt = left_r;
        bbank_nxt = bbank_r;
        ap_nxt = ap_r;
        full_nxt = full_r;
        auto_step = 1'b0;
        if (st_r == sprc_pkg::ST_SELF) begin
            // only clock enable is watched here
            if (cke_in) begin
                st_nxt = sprc_pkg::ST_IDLE;
            end
        end else begin
            // burst countdown and auto precharge at end
            if (st_r == sprc_pkg::ST_BURST && !full_r) begin
                if (left_r == 9'h001) begin
                    st_nxt = sprc_pkg::ST_IDLE;
                    if (ap_r) begin
                        open_nxt[bbank_r] = 1'b0;
                    end
                    ap_nxt = 1'b0;
                end else begin
                    left_nxt = left_r - 9'h001;
                end
            end
            if (is_cmd(cmd_in, sprc_pkg::CMD_ACTIVE) && cke_in) begin
                open_nxt[cmd_in.bank] = 1'b1;
            end else if (is_cmd(cmd_in, sprc_pkg::CMD_PRECHARGE) && cke_in) begin
                // AP bit set closes every bank, else only the addressed bank closes
                if (cmd_in.addr[sprc_pkg::AP_BIT]) begin
                    open_nxt = '0;
                end else begin
                    open_nxt[cmd_in.bank] = 1'b0;
                end
            end else if ((is_cmd(cmd_in, sprc_pkg::CMD_READ)
                          || is_cmd(cmd_in, sprc_pkg::CMD_WRITE)) && cke_in) begin
                // per-command auto precharge choice
                st_nxt = sprc_pkg::ST_BURST;
                bbank_nxt = cmd_in.bank;
                full_nxt = (burst_len_in == sprc_pkg::FULL_PAGE_LEN);
                ap_nxt = cmd_in.addr[sprc_pkg::AP_BIT]
                    && (burst_len_in != sprc_pkg::FULL_PAGE_LEN);
                left_nxt = burst_len_in;
            end else if (is_cmd(cmd_in, sprc_pkg::CMD_BURST_TERM) && cke_in) begin
                // cut latest burst, row stays open
                st_nxt = sprc_pkg::ST_IDLE;
                ap_nxt = 1'b0;
                full_nxt = 1'b0;
            end else if (is_cmd(cmd_in, sprc_pkg::CMD_REFRESH)) begin
                if (cke_in) begin
                    auto_step = 1'b1; // single refresh
                end else if (!AUTOMOTIVE_GRADE) begin
                    st_nxt = sprc_pkg::ST_SELF;
                    ap_nxt = 1'b0;
                    full_nxt = 1'b0;
                end
            end
        end
    end

    // registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= sprc_pkg::ST_IDLE;
            open_r <= '0;
            left_r <= 9'h000;
            bbank_r <= 2'h0;
            ap_r <= 1'b0;
            full_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            open_r <= open_nxt;
            left_r <= left_nxt;
            bbank_r <= bbank_nxt;
            ap_r <= ap_nxt;
            full_r <= full_nxt;
        end
    end

    assign in_self = (st_r == sprc_pkg::ST_SELF) && !cke_in;

    // shared row counter and self refresh timer
    sprc_refresh_counter #(
        .PERIOD_CYC(SELF_CYC)
    ) u_cnt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .auto_step_in(auto_step),
        .self_in(in_self),
        .row_out(refresh_row_out),
        .refresh_pulse_out(refresh_strobe_out)
    );

    assign bank_open_out = open_r;
    assign burst_active_out = (st_r == sprc_pkg::ST_BURST);
    assign self_refresh_out = (st_r == sprc_pkg::ST_SELF);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_AP_CLOSE: assert property (@(posedge clk_in) disable iff (rst_in)
        (st_r == sprc_pkg::ST_BURST && !full_r && left_r == 9'h001 && ap_r
         && !(is_cmd(cmd_in, sprc_pkg::CMD_ACTIVE) && cke_in))
        |=> !bank_open_out[$past(bbank_r)])
        else $error("auto precharge did not close bank");
    AST_FULL_NO_AP: assert property (@(posedge clk_in) disable iff (rst_in)
        full_r |-> !ap_r)
        else $error("auto precharge armed on full page");
    AST_AP_ONESHOT: assert property (@(posedge clk_in) disable iff (rst_in)
        (cke_in && (is_cmd(cmd_in, sprc_pkg::CMD_READ) || is_cmd(cmd_in, sprc_pkg::CMD_WRITE))
         && !cmd_in.addr[sprc_pkg::AP_BIT]) |=> !ap_r)
        else $error("auto precharge persisted");
    AST_BT_STOP: assert property (@(posedge clk_in) disable iff (rst_in)
        (cke_in && st_r != sprc_pkg::ST_SELF && is_cmd(cmd_in, sprc_pkg::CMD_BURST_TERM))
        |=> !burst_active_out)
        else $error("burst terminate ignored");
    AST_BT_OPEN: assert property (@(posedge clk_in) disable iff (rst_in)
        (cke_in && st_r != sprc_pkg::ST_SELF && is_cmd(cmd_in, sprc_pkg::CMD_BURST_TERM))
        |=> bank_open_out == $past(bank_open_out))
        else $error("burst terminate changed row state");
    AST_AUTO_REF: assert property (@(posedge clk_in) disable iff (rst_in)
        (cke_in && st_r != sprc_pkg::ST_SELF && is_cmd(cmd_in, sprc_pkg::CMD_REFRESH))
        |=> refresh_strobe_out && (refresh_row_out == $past(refresh_row_out) + 12'h001))
        else $error("auto refresh did not step counter");
    AST_SELF_ENTER: assert property (@(posedge clk_in) disable iff (rst_in)
        (!cke_in && st_r != sprc_pkg::ST_SELF && is_cmd(cmd_in, sprc_pkg::CMD_REFRESH))
        |=> self_refresh_out == !AUTOMOTIVE_GRADE)
        else $error("self refresh entry wrong");
    AST_SELF_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
        (self_refresh_out && !cke_in) |=> self_refresh_out && $stable(bank_open_out))
        else $error("input acted in self refresh");
    AST_SELF_INT: assert property (@(posedge clk_in) disable iff (rst_in)
        (self_refresh_out && !cke_in) ##1 refresh_strobe_out
        |-> refresh_row_out == $past(refresh_row_out) + 12'h001)
        else $error("self refresh pulse without row step");
    AST_NO_SELF_AT: assert property (@(posedge clk_in) disable iff (rst_in)
        AUTOMOTIVE_GRADE |-> !self_refresh_out)
        else $error("self refresh on automotive grade");
endmodule
`default_nettype wire

/* File: design/sprc_pkg.sv */
// Purpose: shared constants and types for precharge/refresh control
// Assumes: 40 MHz clock, four banks, 12-bit row refresh counter
// Notes: command encodings follow the usual cs/ras/cas/we pin order
package sprc_pkg;
    // ------------------------------------------------------------
    // command encodings {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_ACTIVE = 4'h3;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_BURST_TERM = 4'h6;
    // ------------------------------------------------------------
    // field positions and sizes
    // ------------------------------------------------------------
    localparam int AP_BIT = 10;
    localparam int ROW_W = 12;
    localparam int BANKS = 4;
    localparam logic [8:0] FULL_PAGE_LEN = 9'h100;
    localparam logic [ROW_W-1:0] REF_CNT_RST = 12'h000;
    // ------------------------------------------------------------
    // timing: internal refresh period in self refresh
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SELF_REF_PERIOD_NS = 15625;
    localparam int SELF_REF_CYC = SELF_REF_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BURST_W = 9;
    // ------------------------------------------------------------
    // bus bundles
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cmd;
        logic [1:0] bank;
        logic [11:0] addr;
    } sprc_cmd_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BURST = 2'b01,
        ST_SELF = 2'b10
    } sprc_state_t;
endpackage

/* File: design/sprc_refresh_counter.sv */
// Purpose: shared row refresh counter with self refresh timer
// Assumes: step pulse from auto refresh, self flag from control
// Notes: one counter serves both refresh modes
`timescale 1ns/10ps
`default_nettype none
module sprc_refresh_counter #(
    parameter int PERIOD_CYC = sprc_pkg::SELF_REF_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic auto_step_in,
    input wire logic self_in,
    output logic [sprc_pkg::ROW_W-1:0] row_out,
    output logic refresh_pulse_out
);
    logic [sprc_pkg::ROW_W-1:0] row_r, row_nxt;
    logic [15:0] tmr_r, tmr_nxt;
    logic pulse_r, pulse_nxt;
    // ------------------------------------------------------------
    // next-value logic
    // ------------------------------------------------------------
    always_comb begin
        row_nxt = row_r;
        tmr_nxt = 16'h0000;
        pulse_nxt = 1'b0;
        if (self_in) begin
            // internal timing while in self refresh
            if (tmr_r == 16'(PERIOD_CYC - 1)) begin
                pulse_nxt = 1'b1;
                row_nxt = row_r + 12'h001;
            end else begin
                tmr_nxt = tmr_r + 16'h0001;
            end
        end else if (auto_step_in) begin
            pulse_nxt = 1'b1;
            row_nxt = row_r + 12'h001;
        end
    end
    // registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            row_r <= sprc_pkg::REF_CNT_RST;
            tmr_r <= 16'h0000;
            pulse_r <= 1'b0;
        end else begin
            row_r <= row_nxt;
            tmr_r <= tmr_nxt;
            pulse_r <= pulse_nxt;
        end
    end
    assign row_out = row_r;
    assign refresh_pulse_out = pulse_r;
endmodule
`default_nettype wire

/* File: sim/sprc_core_tb_top.sv */
// Purpose: self-checking bench for the precharge and refresh core
// Assumes: internal self refresh period shortened to 4 cycles
// Notes: a second core of automotive grade shares all inputs
`timescale 1ns/10ps
`default_nettype none
module sprc_core_tb_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    sprc_pkg::sprc_cmd_t cmd;
    logic cke, burst, self_ref, self_ref_a, strobe;
    logic [8:0] blen;
    logic [3:0] bank_open;
    logic [11:0] row, exp_row;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam int SELF_CYC_SIM = 4;
    always #12.5 clk_in = ~clk_in;
    sprc_ctrl_model u_ctrl (.clk_in(clk_in), .cmd_out(cmd), .cke_out(cke), .burst_len_out(blen));
    sprc_core #(.SELF_CYC(SELF_CYC_SIM)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .cke_in(cke),
        .cmd_in(cmd), .burst_len_in(blen), .bank_open_out(bank_open), .burst_active_out(burst),
        .self_refresh_out(self_ref), .refresh_row_out(row), .refresh_strobe_out(strobe));
    sprc_core #(.AUTOMOTIVE_GRADE(1'b1), .SELF_CYC(SELF_CYC_SIM)) u_dut_auto (.clk_in(clk_in),
        .rst_in(rst_in), .cke_in(cke), .cmd_in(cmd), .burst_len_in(blen), .bank_open_out(),
        .burst_active_out(), .self_refresh_out(self_ref_a), .refresh_row_out(),
        .refresh_strobe_out());
    // --------------------------------
    // checking and closing
    // --------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            finish_test();
        end
    end
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_auto_precharge();
        u_ctrl.issue(sprc_pkg::CMD_ACTIVE, 2'h1, 12'h000, 9'h001, 1'b1);
        u_ctrl.issue(sprc_pkg::CMD_READ, 2'h1, 12'h400, 9'h002, 1'b1);
        #1 check(burst, 1'b1);
        @(posedge clk_in) #1 check(burst, 1'b1);
        @(posedge clk_in) #1 check(burst, 1'b0);
        check(bank_open[1], 1'b0);
    endtask
    task automatic t_one_shot();
        u_ctrl.issue(sprc_pkg::CMD_ACTIVE, 2'h1, 12'h000, 9'h001, 1'b1);
        u_ctrl.issue(sprc_pkg::CMD_READ, 2'h1, 12'h000, 9'h001, 1'b1);
        u_ctrl.issue(sprc_pkg::CMD_ACTIVE, 2'h2, 12'h000, 9'h001, 1'b1);
        u_ctrl.issue(sprc_pkg::CMD_WRITE, 2'h2, 12'h400, 9'h004, 1'b1);
        repeat (5) @(posedge clk_in);
        #1 check(bank_open, 4'h2);
        u_ctrl.issue(sprc_pkg::CMD_PRECHARGE, 2'h0, 12'h400, 9'h001, 1'b1);
        #1 check(bank_open, 4'h0);
    endtask
    task automatic t_terminate();
        for (int i = 0; i < 2; i++) begin
            u_ctrl.issue(sprc_pkg::CMD_ACTIVE, 2'h3, 12'h000, 9'h001, 1'b1);
            u_ctrl.issue(i ? sprc_pkg::CMD_READ : sprc_pkg::CMD_WRITE, 2'h3,
                i ? 12'h400 : 12'h000, i ? sprc_pkg::FULL_PAGE_LEN : 9'h008, 1'b1);
            repeat (3) @(posedge clk_in);
            u_ctrl.issue(sprc_pkg::CMD_BURST_TERM, 2'h3, 12'h000, 9'h001, 1'b1);
            #1 check(burst, 1'b0);
            repeat (4) @(posedge clk_in);
            #1 check(bank_open[3], 1'b1);
            u_ctrl.issue(sprc_pkg::CMD_PRECHARGE, 2'h3, 12'h000, 9'h001, 1'b1);
            #1 check(bank_open[3], 1'b0);
        end
    endtask
    task automatic t_auto_refresh();
        for (int i = 0; i < 3; i++) begin
            u_ctrl.issue(sprc_pkg::CMD_REFRESH, 2'(i), 12'(i) * 12'h555, 9'h001, 1'b1);
            exp_row++;
            #1 check(strobe, 1'b1);
            check(row, exp_row);
            @(posedge clk_in) #1 check(strobe, 1'b0);
        end
    endtask
    task automatic t_self_refresh();
        int gap;
        u_ctrl.issue(sprc_pkg::CMD_REFRESH, 2'h0, 12'h000, 9'h001, 1'b0);
        #1 check(self_ref, 1'b1);
        check(self_ref_a, 1'b0);
        for (int k = 0; k < 2; k++) begin
            gap = 0;
            while (strobe !== 1'b1 && gap < 20) begin
                @(posedge clk_in) #1 gap++;
            end
            exp_row++;
            check(row, exp_row);
            // strobes come SELF_CYC_SIM apart; the count starts one cycle after a strobe
            if (k == 1) check(16'(gap), 16'(SELF_CYC_SIM - 1));
            @(posedge clk_in) #1;
        end
        u_ctrl.issue(sprc_pkg::CMD_ACTIVE, 2'h2, 12'h000, 9'h001, 1'b0);
        #1 check(bank_open, 4'h0);
        check(self_ref, 1'b1);
        u_ctrl.leave_self();
        #1 check(self_ref, 1'b0);
        // one more internal refresh lands on the edge at which cke rises
        exp_row++;
        check(row, exp_row);
        u_ctrl.issue(sprc_pkg::CMD_REFRESH, 2'h0, 12'h000, 9'h001, 1'b1);
        exp_row++;
        #1 check(row, exp_row);
        check(16'(u_ctrl.ref_late), 16'h0000);
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        exp_row = sprc_pkg::REF_CNT_RST;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        #1 check({bank_open, burst, strobe, self_ref, 9'h000}, 16'h0000);
        check(16'(row), 16'(sprc_pkg::REF_CNT_RST));
        t_auto_precharge();
        t_one_shot();
        t_terminate();
        t_auto_refresh();
        t_self_refresh();
        finish_test();
    end
endmodule
`default_nettype wire

/* File: sim/sprc_ctrl_model.sv */
// Purpose: memory controller model that issues commands to the core
// Assumes: clk_in runs steadily the whole run, so cke rises on a good clock
// Notes: after the time-0 defaults, every drive lands by non-blocking assignment on a rising edge
`timescale 1ns/10ps
`default_nettype none
module sprc_ctrl_model #(
    parameter int PRECHARGE_RECOVERY_CYC = 3,
    parameter int EXIT_CYC = 2,
    parameter int ROW_ACTIVE_MIN_CYC = 2,
    parameter int REFRESH_GAP_CYC = 625 // one refresh per 15.625us
) (
    input wire logic clk_in,
    output var sprc_pkg::sprc_cmd_t cmd_out,
    output var logic cke_out,
    output var logic [8:0] burst_len_out
);
    // --------------------------------
    // bank timers and command issue
    // --------------------------------
    int cyc = 0;
    int quiet_until = 0;
    int self_since = 0;
    int ready [sprc_pkg::BANKS] = '{default: 0}; // per-bank timer
    int refresh_due = REFRESH_GAP_CYC; // refresh interval deadline
    logic ref_late = 1'b0;
    initial begin
        cmd_out = '{cmd: sprc_pkg::CMD_NOP, bank: 2'h0, addr: 12'h000};
        cke_out = 1'b1;
        burst_len_out = 9'h001;
    end
    always @(posedge clk_in) cyc <= cyc + 1;
    // one command then a nop; each refresh is its own command
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
                         input logic [8:0] len, input logic cke);
        while (cyc < ready[b] || cyc < quiet_until) @(posedge clk_in);
        @(posedge clk_in);
        cmd_out <= '{cmd: c, bank: b, addr: a};
        cke_out <= cke;
        burst_len_out <= len;
        if ((c == sprc_pkg::CMD_READ || c == sprc_pkg::CMD_WRITE) && a[sprc_pkg::AP_BIT]
            && len != sprc_pkg::FULL_PAGE_LEN)
            ready[b] = cyc + int'(len) + PRECHARGE_RECOVERY_CYC;
        if (c == sprc_pkg::CMD_REFRESH && !cke)
            self_since = cyc;
        if (c == sprc_pkg::CMD_REFRESH && cke) begin
            if (cyc > refresh_due) ref_late = 1'b1;
            refresh_due = cyc + REFRESH_GAP_CYC;
        end
        @(posedge clk_in);
        cmd_out <= '{cmd: sprc_pkg::CMD_NOP, bank: 2'h0, addr: 12'h000};
    endtask
    // cke stays low for the minimum stay, then rises with nops after
    task automatic leave_self();
        while (cyc < self_since + ROW_ACTIVE_MIN_CYC) @(posedge clk_in);
        @(posedge clk_in);
        cke_out <= 1'b1;
        quiet_until = cyc + EXIT_CYC + 1;
        refresh_due = cyc + REFRESH_GAP_CYC;
        @(posedge clk_in);
    endtask
endmodule
`default_nettype wire
